// *** shared/ltm_pkg.sv ***
// Shared constants and types for the loop group time-division multiplexer.
// Assumes a single 250 MHz reference clock and an AHB-Lite register port.
`default_nettype none
package ltm_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   // Reference clock rate and group rates, in kHz and kb/s.
   localparam int LTM_REF_CLK_KHZ = 250000;
   localparam int LTM_GRP_RATE_HI_KBPS = 144;
   localparam int LTM_GRP_RATE_LO_KBPS = 72;
   // Reference cycles per group bit, rounded down.
   localparam logic [11:0] LTM_DIV_HI = 12'(LTM_REF_CLK_KHZ / LTM_GRP_RATE_HI_KBPS);
   localparam logic [11:0] LTM_DIV_LO = 12'(LTM_REF_CLK_KHZ / LTM_GRP_RATE_LO_KBPS);

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   // Nine slots a frame: eight loop bits then one overhead bit.
   localparam logic [3:0] LTM_SLOT_OVH = 4'h8;
   localparam logic [1:0] LTM_SUB_FRAMING = 2'h0;
   localparam logic [1:0] LTM_SUB_TELEM = 2'h1;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   localparam logic [7:0] LTM_ADDR_CTRL = 8'h00;
   localparam logic [7:0] LTM_ADDR_STATUS = 8'h04;
   localparam int LTM_CTRL_ENABLE = 0;
   localparam int LTM_CTRL_RATE_HI = 1;
   localparam int LTM_CTRL_EXT_CLK = 2;
   localparam logic [2:0] LTM_CTRL_RESET = 3'h0;
   // The encryption-device resync option is fixed at not equipped.
   localparam logic LTM_CRYPTO_EQUIPPED = 1'b0;

   // Commands from the framing synchronizer, sampled together.
   typedef struct packed {
      logic pattern_alt;
      logic data_zero;
   } ltm_sync_cmd_t;

endpackage
`default_nettype wire

// *** hw/ltm_mux.sv ***
// Loop group multiplexer and demultiplexer with an AHB-Lite register port.
// Assumes the framing synchronizer and test logic drive synchronous inputs.
`timescale 1ns/100ps
`default_nettype none

module ltm_mux
   import ltm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // External group clock tick, one cycle per group bit
   input wire logic grp_ext_tick,
   // Loop side
   input wire logic [3:0] loop_tx_data,
   output logic [3:0] loop_tx_take,
   output logic [3:0] loop_rx_data,
   output logic [3:0] loop_rx_stb,
   // Group side
   output logic grp_tx_data,
   output logic grp_tx_stb,
   input wire logic grp_rx_data,
   input wire logic grp_rx_frame_ref,
   // Framing synchronizer commands, with no frame search inhibit.
   input wire ltm_sync_cmd_t sync_cmd,
   // Telemetry and test logic
   input wire logic telem_tx_in,
   input wire logic test_loop_gate,
   input wire logic test_summary_err,
   output logic telem_rx_out,
   output logic [3:0] ovh_rx_data
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // True when the slot number is the overhead slot.
   function automatic logic is_ovh(input logic [3:0] slot);
      is_ovh = (slot == LTM_SLOT_OVH);
   endfunction

   // Next slot number modulo nine.
   function automatic logic [3:0] next_slot(input logic [3:0] slot);
      next_slot = is_ovh(slot) ? 4'h0 : 4'(slot + 4'h1);
   endfunction

   logic [2:0] ctrl_ff;
   logic [11:0] div_ff;
   logic bit_tick;
   logic [3:0] tx_slot_ff;
   logic [1:0] tx_sub_ff;
   logic fr_phase_ff;
   ltm_sync_cmd_t cmd_ff;
   logic grp_tx_data_ff;
   logic grp_tx_stb_ff;
   logic [3:0] loop_tx_take_ff;
   logic telem_tx_bit_ff;
   logic [3:0] rx_slot_ff;
   logic [1:0] rx_sub_ff;
   logic [3:0] rx_cur_slot;
   logic [1:0] rx_cur_sub;
   logic [3:0] loop_rx_data_ff;
   logic [3:0] loop_rx_stb_ff;
   logic [3:0] ovh_rx_data_ff;
   logic telem_rx_out_ff;
   logic nxt_tx_bit;
   logic telem_src;
   logic ap_valid_ff;
   logic ap_write_ff;
   logic [7:0] ap_addr_ff;
   logic [31:0] hrdata_ff;

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   // The slave never stalls and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   // Captures the address phase of a transfer.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ap_valid_ff <= 1'b0;
         ap_write_ff <= 1'b0;
         ap_addr_ff <= 8'h00;
      end else if (hready) begin
         ap_valid_ff <= hsel && htrans[1];
         ap_write_ff <= hwrite;
         ap_addr_ff <= haddr;
      end
   end

   // Read data is prepared in the address phase; unmapped offsets read zero.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr)
            LTM_ADDR_CTRL: hrdata_ff <= {29'h0000_0000, ctrl_ff};
            LTM_ADDR_STATUS: hrdata_ff <= {17'h0_0000, LTM_CRYPTO_EQUIPPED,
                                           cmd_ff, rx_sub_ff, rx_slot_ff, tx_sub_ff, tx_slot_ff};
            default: hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // Control register: enable, rate family and clock source.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= LTM_CTRL_RESET;
      end else if (ap_valid_ff && ap_write_ff && ap_addr_ff == LTM_ADDR_CTRL) begin
         ctrl_ff <= hwdata[2:0];
      end
   end

   // ------------------------------------------------------------
   // Group bit timing
   // ------------------------------------------------------------
   // Divides the reference clock to the 72 or 144 kb/s group rate.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_ff <= 12'h000;
      end else if (!ctrl_ff[LTM_CTRL_ENABLE] || div_ff == 12'h000) begin
         div_ff <= 12'((ctrl_ff[LTM_CTRL_RATE_HI] ? LTM_DIV_HI : LTM_DIV_LO) - 12'h001);
      end else begin
         div_ff <= 12'(div_ff - 12'h001);
      end
   end

   // External ticks already arrive at the group rate.
   assign bit_tick = ctrl_ff[LTM_CTRL_ENABLE] &&
                     (ctrl_ff[LTM_CTRL_EXT_CLK] ? grp_ext_tick : div_ff == 12'h000);

   // ------------------------------------------------------------
   // Transmit sequencer
   // ------------------------------------------------------------
   // Nine-slot counter and overhead subchannel rotation.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_slot_ff <= 4'h0;
         tx_sub_ff <= 2'h0;
      end else if (bit_tick) begin
         tx_slot_ff <= next_slot(tx_slot_ff);
         if (is_ovh(tx_slot_ff)) begin
            tx_sub_ff <= 2'(tx_sub_ff + 2'h1);
         end
      end
   end

   // Commands are sampled each group bit so a slot never changes mid-bit.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_ff <= '0;
      end else if (bit_tick) begin
         cmd_ff <= sync_cmd;
      end
   end

   // Framing phase toggles on every framing bit sent.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fr_phase_ff <= 1'b1;
      end else if (bit_tick && is_ovh(tx_slot_ff) && tx_sub_ff == LTM_SUB_FRAMING) begin
         fr_phase_ff <= !fr_phase_ff;
      end
   end

   // Test error replaces telemetry with zeros at the subchannel mux.
   assign telem_src = test_summary_err ? 1'b0 : telem_tx_in;

   // Loop mux and subchannel mux; the third mux has no inputs in use.
   always_comb begin
      nxt_tx_bit = 1'b0;
      if (!is_ovh(tx_slot_ff)) begin
         nxt_tx_bit = cmd_ff.data_zero ? 1'b0 : loop_tx_data[tx_slot_ff[1:0]];
      end else begin
         unique case (tx_sub_ff)
            2'h0: nxt_tx_bit = cmd_ff.pattern_alt ? fr_phase_ff : 1'b1;
            2'h1: nxt_tx_bit = telem_src;
            2'h2, 2'h3: nxt_tx_bit = 1'b1;
         endcase
      end
   end

   // Group output bit, its strobe and the loop take pulses.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         grp_tx_data_ff <= 1'b1;
         grp_tx_stb_ff <= 1'b0;
         loop_tx_take_ff <= 4'h0;
      end else begin
         grp_tx_stb_ff <= bit_tick;
         loop_tx_take_ff <= 4'h0;
         if (bit_tick) begin
            grp_tx_data_ff <= nxt_tx_bit;
            if (!is_ovh(tx_slot_ff)) begin
               loop_tx_take_ff <= 4'(4'h1 << tx_slot_ff[1:0]);
            end
         end
      end
   end

   // Holds the last telemetry bit sent, for the loopback gate.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         telem_tx_bit_ff <= 1'b0;
      end else if (bit_tick && is_ovh(tx_slot_ff) && tx_sub_ff == LTM_SUB_TELEM) begin
         telem_tx_bit_ff <= telem_src;
      end
   end

   assign grp_tx_data = grp_tx_data_ff;
   assign grp_tx_stb = grp_tx_stb_ff;
   assign loop_tx_take = loop_tx_take_ff;

   // ------------------------------------------------------------
   // Receive frame regenerator
   // ------------------------------------------------------------
   // A frame reference forces the current bit to slot zero, subchannel zero.
   assign rx_cur_slot = grp_rx_frame_ref ? 4'h0 : rx_slot_ff;
   assign rx_cur_sub = grp_rx_frame_ref ? 2'h0 : rx_sub_ff;

   // Regenerated slot and subchannel counters, phased by the reference.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_slot_ff <= 4'h0;
         rx_sub_ff <= 2'h0;
      end else if (bit_tick) begin
         rx_slot_ff <= next_slot(rx_cur_slot);
         rx_sub_ff <= is_ovh(rx_cur_slot) ? 2'(rx_cur_sub + 2'h1) : rx_cur_sub;
      end
   end

   // ------------------------------------------------------------
   // Receive demultiplexer
   // ------------------------------------------------------------
   // Loop bits and overhead subchannel bits go to their own outputs.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         loop_rx_data_ff <= 4'h0;
         loop_rx_stb_ff <= 4'h0;
         ovh_rx_data_ff <= 4'hF;
      end else begin
         loop_rx_stb_ff <= 4'h0;
         if (bit_tick && !is_ovh(rx_cur_slot)) begin
            loop_rx_data_ff[rx_cur_slot[1:0]] <= grp_rx_data;
            loop_rx_stb_ff <= 4'(4'h1 << rx_cur_slot[1:0]);
         end else if (bit_tick) begin
            ovh_rx_data_ff[rx_cur_sub] <= grp_rx_data;
         end
      end
   end

   // Telemetry output: received bit, looped-back bit, or zeros on error.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         telem_rx_out_ff <= 1'b0;
      end else if (bit_tick && is_ovh(rx_cur_slot) && rx_cur_sub == LTM_SUB_TELEM) begin
         if (test_summary_err) begin
            telem_rx_out_ff <= 1'b0;
         end else begin
            telem_rx_out_ff <= test_loop_gate ? telem_tx_bit_ff : grp_rx_data;
         end
      end
   end

   assign loop_rx_data = loop_rx_data_ff;
   assign loop_rx_stb = loop_rx_stb_ff;
   assign ovh_rx_data = ovh_rx_data_ff;
   assign telem_rx_out = telem_rx_out_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_fixed_ones: assert property (
      bit_tick && is_ovh(tx_slot_ff) && tx_sub_ff[1] |=> grp_tx_data_ff)
      else $error("fixed overhead subchannel not one");
   a_data_forced_zero: assert property (
      bit_tick && !is_ovh(tx_slot_ff) && cmd_ff.data_zero |=> !grp_tx_data_ff)
      else $error("data slot not forced to zero");
   a_framing_ones: assert property (
      bit_tick && is_ovh(tx_slot_ff) && tx_sub_ff == 2'h0 && !cmd_ff.pattern_alt
      |=> grp_tx_data_ff)
      else $error("all-ones framing bit lost");
   a_slot_wrap: assert property (
      bit_tick && is_ovh(tx_slot_ff) |=> tx_slot_ff == 4'h0)
      else $error("slot counter did not wrap after nine");
   a_sub_rotate: assert property (
      bit_tick && is_ovh(tx_slot_ff) |=> tx_sub_ff == 2'($past(tx_sub_ff) + 2'h1))
      else $error("overhead subchannel did not advance");
   a_tick_spacing: assert property (
      bit_tick && !ctrl_ff[LTM_CTRL_EXT_CLK] |=> !bit_tick [*8])
      else $error("group bit ticks too close");
   a_rx_align: assert property (
      bit_tick && grp_rx_frame_ref |=> rx_slot_ff == 4'h1 && rx_sub_ff == 2'h0)
      else $error("regenerator not aligned to frame reference");
   a_telem_break: assert property (
      bit_tick && is_ovh(rx_cur_slot) && rx_cur_sub == 2'h1 && test_summary_err
      |=> !telem_rx_out_ff)
      else $error("telemetry not zeroed on test error");
   a_loop_take: assert property (
      bit_tick && !is_ovh(tx_slot_ff) |=> $onehot(loop_tx_take_ff) && grp_tx_stb_ff)
      else $error("loop take pulse missing");

endmodule

`default_nettype wire

// *** tb/ltm_group_model.sv ***
// Model of the group modem and framing synchronizer facing the loop group mux.
// Assumes the bench supplies the reference clock and the active-low reset.
`timescale 1ns/100ps
`default_nettype none
module ltm_group_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Pace select, 1 gives a slower group clock
   input wire logic slow,
   // Group link
   input wire logic tx_data,
   input wire logic tx_stb,
   output logic tick,
   output logic rx_data,
   output logic frame_ref
);
   // ------------------------------------------------------------
   // Group clock and loopback
   // ------------------------------------------------------------
   logic [3:0] gap_ff;
   int idx_ff;

   // One-cycle group bit tick every 5 or 12 reference cycles.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_ff <= 4'h0;
         tick <= 1'b0;
      end else begin
         tick <= (gap_ff == 4'h0);
         gap_ff <= (gap_ff == 4'h0) ? (slow ? 4'hB : 4'h4) : gap_ff - 4'h1;
      end
   end

   // Each sent bit comes back, flagged when it opened a 36-bit superframe.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_ff <= 0;
         rx_data <= 1'b1;
         frame_ref <= 1'b0;
      end else if (tx_stb) begin
         rx_data <= tx_data;
         frame_ref <= (idx_ff % 36 == 0);
         idx_ff <= idx_ff + 1;
      end
   end
endmodule
`default_nettype wire

// *** tb/loop_group_tdm_mux_bench.sv ***
// Self-checking bench for the loop group multiplexer and demultiplexer.
// Assumes the group model loops transmit data back and supplies the bit tick.
`timescale 1ns/100ps
`default_nettype none
module loop_group_tdm_mux_bench
   import ltm_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic ref_clk, reset_n, hsel, hwrite, slow, telem_tx_in, gate, err, chk_en;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic hreadyout, hresp, grp_tx_data, grp_tx_stb, tick, grx, fref, telem_rx_out, prev_fr;
   logic [3:0] loop_tx_data, loop_tx_take, loop_rx_data, loop_rx_stb, ovh_rx_data;
   ltm_sync_cmd_t sync_cmd;
   int num_errors, n_compared, tx_idx, slot, sub;
   bit fr_ok;

   ltm_mux DUT (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .grp_ext_tick(tick),
      .loop_tx_data(loop_tx_data), .loop_tx_take(loop_tx_take), .loop_rx_data(loop_rx_data),
      .loop_rx_stb(loop_rx_stb), .grp_tx_data(grp_tx_data), .grp_tx_stb(grp_tx_stb),
      .grp_rx_data(grx), .grp_rx_frame_ref(fref), .sync_cmd(sync_cmd),
      .telem_tx_in(telem_tx_in), .test_loop_gate(gate), .test_summary_err(err),
      .telem_rx_out(telem_rx_out), .ovh_rx_data(ovh_rx_data));

   ltm_group_model partner (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
      .tx_data(grp_tx_data), .tx_stb(grp_tx_stb), .tick(tick), .rx_data(grx),
      .frame_ref(fref));

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic results();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One AHB-Lite single word transfer, holding each phase until hready.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100) begin num_errors++; results(); end
   endtask

   // Waits for k group bits under a bounded count of cycles.
   task automatic wait_bits(input int k);
      int c, n;
      c = 0;
      n = 0;
      while (c < k && n < k * 4000) begin
         @(posedge ref_clk);
         n++;
         if (grp_tx_stb === 1'b1) c++;
      end
      if (c < k) begin num_errors++; results(); end
   endtask

   // Judges every transmitted bit, strobe and received loop bit while enabled, save an alternating framing bit not preceded by an enabled alternating one.
   always @(posedge ref_clk) begin
      if (grp_tx_stb === 1'b1) begin
         slot = tx_idx % 9;
         sub = (tx_idx / 9) % 4;
         if (chk_en && slot < 8) begin
            check(grp_tx_data, sync_cmd.data_zero ? 1'b0 : loop_tx_data[slot % 4]);
            check(loop_tx_take, 4'h1 << (slot % 4));
         end else if (chk_en) begin
            check(loop_tx_take, 4'h0);
            if (sub == 0 && sync_cmd.pattern_alt && fr_ok) check(grp_tx_data, !prev_fr);
            if (sub == 0 && !sync_cmd.pattern_alt) check(grp_tx_data, 1'b1);
            if (sub == 1) check(grp_tx_data, err ? 1'b0 : telem_tx_in);
            if (sub > 1) check(grp_tx_data, 1'b1);
         end
         if (slot == 8 && sub == 0) begin
            prev_fr = grp_tx_data;
            fr_ok = chk_en && sync_cmd.pattern_alt;
         end
         tx_idx++;
      end
      if (chk_en && loop_rx_stb !== 4'h0)
         check(loop_rx_data & loop_rx_stb, (sync_cmd.data_zero ? 4'h0 : loop_tx_data) & loop_rx_stb);
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Settles new inputs, checks two superframes, then the receive outputs.
   task automatic run(input logic [3:0] ld, input logic a, input logic z, input logic t,
         input logic g, input logic e, input logic s);
      chk_en = 1'b0;
      loop_tx_data <= ld;
      sync_cmd <= '{pattern_alt: a, data_zero: z};
      telem_tx_in <= t;
      gate <= g;
      err <= e;
      slow <= s;
      wait_bits(4);
      chk_en = 1'b1;
      wait_bits(72);
      chk_en = 1'b0;
      check(ovh_rx_data[3:2], 2'h3);
      check(telem_rx_out, e ? 1'b0 : t);
   endtask

   // Reset values, disabled link, register access and an unmapped offset.
   task automatic sc_regs();
      check(grp_tx_data, 1'b1);
      check(ovh_rx_data, 4'hF);
      repeat (30) @(posedge ref_clk);
      check(tx_idx, 0);
      ahb(1'b1, LTM_ADDR_CTRL, 32'h0000_0005);
      ahb(1'b0, LTM_ADDR_CTRL, 32'h0);
      check(rd, 32'h0000_0005);
      ahb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
   endtask

   // Normal traffic, fast and slow group clocks, alternating framing.
   task automatic sc_normal();
      run(4'hA, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      run(4'h6, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
   endtask

   // Forced zeros in loop slots with all-ones then alternating framing, and sampled status.
   task automatic sc_zero();
      run(4'h5, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      ahb(1'b0, LTM_ADDR_STATUS, 32'h0);
      check(rd[14:12], 3'h1);
      run(4'h9, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
   endtask

   // Test error breaks the telemetry loop while traffic runs.
   task automatic sc_err();
      run(4'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
   endtask

   // Internal divider period at one group rate.
   task automatic sc_rate(input logic [31:0] ctrl, input logic [11:0] div);
      int n;
      ahb(1'b1, LTM_ADDR_CTRL, ctrl);
      wait_bits(2);
      n = 0;
      do begin @(posedge ref_clk); n++; end while (grp_tx_stb !== 1'b1 && n < 5000);
      check(32'(n), 32'(div));
   endtask

   // ------------------------------------------------------------
   // Clock, reset and main sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   initial begin
      {reset_n, hsel, hwrite, slow, telem_tx_in, gate, err, chk_en} = 8'h00;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      loop_tx_data = 4'h0;
      sync_cmd = '{pattern_alt: 1'b0, data_zero: 1'b0};
      {num_errors, n_compared, tx_idx} = {32'h0, 32'h0, 32'h0};
      fr_ok = 1'b0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      sc_regs();
      sc_normal();
      sc_zero();
      sc_err();
      sc_rate(32'h0000_0003, LTM_DIV_HI);
      sc_rate(32'h0000_0001, LTM_DIV_LO);
      results();
   end
endmodule
`default_nettype wire
